//--- verilog/ietu_regs.svh
`ifndef IETU_REGS_SVH
`define IETU_REGS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses, 32-bit words)
// ----------------------------------------------------------------
`define IETU_NODE_PAGE 4'h0
`define IETU_CHAN_PAGE 4'h1
`define IETU_SRCSEL_ADR 12'h200
`define IETU_ERUCFG_ADR 12'h204
`define IETU_TRAPFLAG_ADR 12'h208
`define IETU_CPUPRIO_ADR 12'h20C
`define IETU_STATUS_ADR 12'h210
`define IETU_ESRCFG_ADR 12'h214
`define IETU_SWTRAP_ADR 12'h218

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IETU_NODE_EN 4
`define IETU_NODE_REQ 5
`define IETU_NODE_ET 6
`define IETU_NODE_CH 7
`define IETU_CH_INCSRC 8
`define IETU_CH_INCDST 9
`define IETU_CH_CONT 10
`define IETU_CH_BYTE 11
`define IETU_ERU_ROUTE 8
`define IETU_ERU_GATE 16
`define IETU_ERU_PAT 24
`define IETU_SR0_BIT 14
`define IETU_SR1_BIT 15
`define IETU_SHARED_BASE 60
`define IETU_ERU_NODE_BASE 56
`define IETU_VEC_NODE_BASE 8'h10

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define IETU_ERUCFG_RST 32'h0000_0000
`define IETU_ESRCFG_RST 4'hF
`define IETU_CPUPRIO_RST 4'h0
`define IETU_LAT_JC 7
`define IETU_LAT_NOJC 11

`endif

//--- verilog/ietu_pkg.sv
`default_nettype none
package ietu_pkg;
  typedef enum logic {IETU_IDLE, IETU_WAIT} ietu_state_t;
  typedef logic [3:0] ietu_prio_t;
endpackage
`default_nettype wire

//--- verilog/ietu_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ietu_regs.svh"
module ietu_top #(
  parameter int CHANS = 8
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CE,
  // Wishbone slave
  input wire logic [11:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  // Request sources
  input wire logic [63:0] NODE_REQ_IN,
  input wire logic [3:0] SHARED_ALT_IN,
  input wire logic [3:0] ERU_IN,
  input wire logic [13:0] TRAP_IN,
  input wire logic [2:0] SERVICE_PIN_IN,
  // Processor core
  input wire logic JUMP_CACHE,
  input wire logic SVC_RETURN,
  output logic REDIRECT,
  output logic [7:0] REDIRECT_VECTOR,
  output logic [3:0] CPU_PRIO,
  output logic [4:0] TRAP_LEVEL,
  // Event transfer
  output logic XFER_VALID,
  output logic [15:0] XFER_SRC,
  output logic [15:0] XFER_DST,
  output logic XFER_BYTE
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] ietu_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic ietu_pick(input logic [2:0] rise, input logic [1:0] sel);
    return (sel == 2'h3) ? 1'b0 : rise[sel];
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic wb_req, wr;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic [3:0] srcsel_ff, nxt_srcsel;
  logic [31:0] erucfg_ff, nxt_erucfg;
  logic [3:0] esrcfg_ff, nxt_esrcfg;
  logic swt_pend_ff, nxt_swt_pend;
  logic [6:0] swt_num_ff, nxt_swt_num;
  logic [3:0] prio_ff [64];
  logic [3:0] nxt_prio [64];
  logic [2:0] ch_ff [64];
  logic [2:0] nxt_ch [64];
  logic [63:0] en_ff, nxt_en, req_ff, nxt_req, et_ff, nxt_et, hw_evt;
  logic [15:0] src_ff [CHANS];
  logic [15:0] nxt_src [CHANS];
  logic [15:0] dst_ff [CHANS];
  logic [15:0] nxt_dst [CHANS];
  logic [11:0] ctl_ff [CHANS];
  logic [11:0] nxt_ctl [CHANS];
  logic [3:0] eru_prev_ff, eru_evt_ff, nxt_eru_evt;
  logic [2:0] esr_prev_ff;
  logic [15:0] tflag_ff, nxt_tflag, tpend_ff, nxt_tpend, trap_evt;
  ietu_pkg::ietu_state_t state_ff, nxt_state;
  logic [3:0] lat_ff, nxt_lat;
  logic redirect_ff, nxt_redirect;
  logic [7:0] vector_ff, nxt_vector;
  ietu_pkg::ietu_prio_t cpu_prio_ff, nxt_cpu_prio, saved_prio_ff, nxt_saved_prio;
  logic [4:0] trap_lvl_ff, nxt_trap_lvl, saved_trap_ff, nxt_saved_trap;
  logic xv_ff, nxt_xv, xb_ff, nxt_xb;
  logic [15:0] xs_ff, nxt_xs, xd_ff, nxt_xd;
  logic vec_any, etc_any, tr_any;
  ietu_pkg::ietu_prio_t vec_prio, etc_prio;
  logic [5:0] vec_idx, etc_idx;
  logic [3:0] tr_idx;
  logic [2:0] etc_ch;
  logic idle, take_sw, take_trap, ok_int, take_etc, take_vec;

  assign wb_req = WB_CYC_I & WB_STB_I;
  // Writes land on the edge where ack is sampled high
  assign wr = wb_req & WB_WE_I & ack_ff;

  // ----------------------------------------------------------------
  // Bus slave and loose control registers
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ack = wb_req & ~ack_ff;
    nxt_dat = dat_ff;
    nxt_srcsel = srcsel_ff;
    nxt_erucfg = erucfg_ff;
    nxt_esrcfg = esrcfg_ff;
    nxt_swt_pend = swt_pend_ff & ~take_sw;
    nxt_swt_num = swt_num_ff;
    if (wr) begin
      if (WB_ADR_I == `IETU_SRCSEL_ADR) nxt_srcsel = WB_SEL_I[0] ? WB_DAT_I[3:0] : srcsel_ff;
      else if (WB_ADR_I == `IETU_ERUCFG_ADR) nxt_erucfg = ietu_merge(erucfg_ff, WB_DAT_I, WB_SEL_I);
      else if (WB_ADR_I == `IETU_ESRCFG_ADR) nxt_esrcfg = WB_SEL_I[0] ? WB_DAT_I[3:0] : esrcfg_ff;
      else if (WB_ADR_I == `IETU_SWTRAP_ADR && WB_SEL_I[0]) begin
        nxt_swt_num = WB_DAT_I[6:0];
        nxt_swt_pend = 1'b1;
      end
    end
    // Read data captured when the request is first seen
    if (wb_req & ~ack_ff) begin
      if (WB_ADR_I[11:8] == `IETU_NODE_PAGE) begin
        nxt_dat = {22'h0, ch_ff[WB_ADR_I[7:2]], et_ff[WB_ADR_I[7:2]], req_ff[WB_ADR_I[7:2]],
                   en_ff[WB_ADR_I[7:2]], prio_ff[WB_ADR_I[7:2]]};
      end else if (WB_ADR_I[11:8] == `IETU_CHAN_PAGE && 32'(WB_ADR_I[7:3]) < CHANS) begin
        nxt_dat = WB_ADR_I[2] ? {20'h0, ctl_ff[WB_ADR_I[5:3]]}
                              : {dst_ff[WB_ADR_I[5:3]], src_ff[WB_ADR_I[5:3]]};
      end else if (WB_ADR_I == `IETU_SRCSEL_ADR) nxt_dat = {28'h0, srcsel_ff};
      else if (WB_ADR_I == `IETU_ERUCFG_ADR) nxt_dat = erucfg_ff;
      else if (WB_ADR_I == `IETU_TRAPFLAG_ADR) nxt_dat = {16'h0, tflag_ff};
      else if (WB_ADR_I == `IETU_CPUPRIO_ADR) nxt_dat = {28'h0, cpu_prio_ff};
      else if (WB_ADR_I == `IETU_STATUS_ADR) begin
        nxt_dat = {22'h0, (state_ff == ietu_pkg::IETU_WAIT), trap_lvl_ff, cpu_prio_ff};
      end else if (WB_ADR_I == `IETU_ESRCFG_ADR) nxt_dat = {28'h0, esrcfg_ff};
      else if (WB_ADR_I == `IETU_SWTRAP_ADR) nxt_dat = {24'h0, swt_pend_ff, swt_num_ff};
      else nxt_dat = 32'h0000_0000;
    end
  end

  // Bus registers
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      srcsel_ff <= 4'h0;
      erucfg_ff <= `IETU_ERUCFG_RST;
      esrcfg_ff <= `IETU_ESRCFG_RST;
      swt_pend_ff <= 1'b0;
      swt_num_ff <= 7'h00;
    end else if (CE) begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      srcsel_ff <= nxt_srcsel;
      erucfg_ff <= nxt_erucfg;
      esrcfg_ff <= nxt_esrcfg;
      swt_pend_ff <= nxt_swt_pend;
      swt_num_ff <= nxt_swt_num;
    end
  end

  // ----------------------------------------------------------------
  // External request preprocessor
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] det;
    logic [3:0] hit;
    logic match;
    det = 4'h0;
    hit = 4'h0;
    match = (ERU_IN == erucfg_ff[`IETU_ERU_PAT +: 4]);
    for (int c = 0; c < 4; c++) begin
      det[c] = (erucfg_ff[2*c] & ERU_IN[c] & ~eru_prev_ff[c]) |
               (erucfg_ff[2*c+1] & ~ERU_IN[c] & eru_prev_ff[c]);
      for (int k = 0; k < 4; k++) begin
        if (erucfg_ff[`IETU_ERU_ROUTE+2*c +: 2] == 2'(k)) hit[k] = hit[k] | det[c];
      end
    end
    for (int k = 0; k < 4; k++) begin
      case (erucfg_ff[`IETU_ERU_GATE+2*k +: 2])
        2'h0: nxt_eru_evt[k] = hit[k];
        2'h1: nxt_eru_evt[k] = hit[k] & match;
        2'h2: nxt_eru_evt[k] = hit[k] & ~match;
        default: nxt_eru_evt[k] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Service pins and trap flags
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] rise;
    rise = SERVICE_PIN_IN & ~esr_prev_ff;
    trap_evt = {ietu_pick(rise, esrcfg_ff[3:2]), ietu_pick(rise, esrcfg_ff[1:0]), TRAP_IN};
    nxt_tflag = tflag_ff;
    if (wr && WB_ADR_I == `IETU_TRAPFLAG_ADR) begin
      nxt_tflag = tflag_ff & ~{(WB_SEL_I[1] ? WB_DAT_I[15:8] : 8'h00),
                               (WB_SEL_I[0] ? WB_DAT_I[7:0] : 8'h00)};
    end
    // One flag per trap, set beats clear
    nxt_tflag = nxt_tflag | trap_evt;
    nxt_tpend = tpend_ff;
    if (take_trap) nxt_tpend[tr_idx] = 1'b0;
    nxt_tpend = nxt_tpend | trap_evt;
  end

  // Preprocessor and trap registers
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      eru_prev_ff <= 4'h0;
      eru_evt_ff <= 4'h0;
      esr_prev_ff <= 3'h0;
      tflag_ff <= 16'h0000;
      tpend_ff <= 16'h0000;
    end else if (CE) begin
      eru_prev_ff <= ERU_IN;
      eru_evt_ff <= nxt_eru_evt;
      esr_prev_ff <= SERVICE_PIN_IN;
      tflag_ff <= nxt_tflag;
      tpend_ff <= nxt_tpend;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration scan
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] c;
    c = 3'h0;
    vec_any = 1'b0;
    etc_any = 1'b0;
    vec_prio = 4'h0;
    etc_prio = 4'h0;
    vec_idx = 6'h00;
    etc_idx = 6'h00;
    tr_any = 1'b0;
    tr_idx = 4'h0;
    for (int i = 0; i < 64; i++) begin
      c = ch_ff[i];
      if (req_ff[i] && en_ff[i]) begin
        // Transfer route until counter runs out
        if (et_ff[i] && (ctl_ff[c][`IETU_CH_CONT] || ctl_ff[c][7:0] != 8'h00)) begin
          if (!etc_any || prio_ff[i] > etc_prio) begin
            etc_any = 1'b1;
            etc_prio = prio_ff[i];
            etc_idx = 6'(i);
          end
        end else if (!vec_any || prio_ff[i] > vec_prio) begin
          vec_any = 1'b1;
          vec_prio = prio_ff[i];
          vec_idx = 6'(i);
        end
      end
    end
    for (int t = 0; t < 16; t++) begin
      // Only traps above the running trap level
      if (tpend_ff[t] && 5'(t + 1) > trap_lvl_ff) begin
        tr_any = 1'b1;
        tr_idx = 4'(t);
      end
    end
  end

  assign etc_ch = ch_ff[etc_idx];
  assign idle = (state_ff == ietu_pkg::IETU_IDLE);
  assign take_sw = idle & swt_pend_ff;
  assign take_trap = idle & ~swt_pend_ff & tr_any;
  // No interrupt or transfer inside a trap service
  assign ok_int = idle & ~swt_pend_ff & ~tr_any & (trap_lvl_ff == 5'h00);
  // Highest enabled priority above the CPU level
  assign take_etc = ok_int & etc_any & (etc_prio > cpu_prio_ff) & (!vec_any || etc_prio >= vec_prio);
  assign take_vec = ok_int & vec_any & (vec_prio > cpu_prio_ff) & ~take_etc;

  // ----------------------------------------------------------------
  // Request nodes
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    hw_evt = NODE_REQ_IN;
    for (int k = 0; k < 4; k++) begin
      if (srcsel_ff[k]) hw_evt[`IETU_SHARED_BASE+k] = SHARED_ALT_IN[k];
      hw_evt[`IETU_ERU_NODE_BASE+k] = hw_evt[`IETU_ERU_NODE_BASE+k] | eru_evt_ff[k];
    end
    nxt_en = en_ff;
    nxt_req = req_ff;
    nxt_et = et_ff;
    for (int i = 0; i < 64; i++) begin
      nxt_prio[i] = prio_ff[i];
      nxt_ch[i] = ch_ff[i];
    end
    // Node control write, request bit included
    if (wr && WB_ADR_I[11:8] == `IETU_NODE_PAGE) begin
      m = ietu_merge({22'h0, ch_ff[WB_ADR_I[7:2]], et_ff[WB_ADR_I[7:2]], req_ff[WB_ADR_I[7:2]],
                      en_ff[WB_ADR_I[7:2]], prio_ff[WB_ADR_I[7:2]]}, WB_DAT_I, WB_SEL_I);
      nxt_prio[WB_ADR_I[7:2]] = m[3:0];
      nxt_en[WB_ADR_I[7:2]] = m[`IETU_NODE_EN];
      nxt_req[WB_ADR_I[7:2]] = m[`IETU_NODE_REQ];
      nxt_et[WB_ADR_I[7:2]] = m[`IETU_NODE_ET];
      nxt_ch[WB_ADR_I[7:2]] = m[`IETU_NODE_CH +: 3];
    end
    if (take_vec) nxt_req[vec_idx] = 1'b0;
    // Last transfer leaves the request for vectored service
    if (take_etc && (ctl_ff[etc_ch][`IETU_CH_CONT] || ctl_ff[etc_ch][7:0] != 8'h01)) begin
      nxt_req[etc_idx] = 1'b0;
    end
    nxt_req = nxt_req | hw_evt;
  end

  // Node registers
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      en_ff <= 64'h0;
      req_ff <= 64'h0;
      et_ff <= 64'h0;
      for (int i = 0; i < 64; i++) begin
        prio_ff[i] <= 4'h0;
        ch_ff[i] <= 3'h0;
      end
    end else if (CE) begin
      en_ff <= nxt_en;
      req_ff <= nxt_req;
      et_ff <= nxt_et;
      prio_ff <= nxt_prio;
      ch_ff <= nxt_ch;
    end
  end

  // ----------------------------------------------------------------
  // Event transfer channels
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] step;
    logic [31:0] mg;
    step = ctl_ff[etc_ch][`IETU_CH_BYTE] ? 16'h0001 : 16'h0002;
    mg = 32'h0;
    for (int c = 0; c < CHANS; c++) begin
      nxt_src[c] = src_ff[c];
      nxt_dst[c] = dst_ff[c];
      nxt_ctl[c] = ctl_ff[c];
      if (wr && WB_ADR_I[11:8] == `IETU_CHAN_PAGE && 32'(WB_ADR_I[7:3]) == c) begin
        if (WB_ADR_I[2]) begin
          mg = ietu_merge({20'h0, ctl_ff[c]}, WB_DAT_I, WB_SEL_I);
          nxt_ctl[c] = mg[11:0];
        end else begin
          {nxt_dst[c], nxt_src[c]} = ietu_merge({dst_ff[c], src_ff[c]}, WB_DAT_I, WB_SEL_I);
        end
      end
      if (take_etc && 32'(etc_ch) == c) begin
        if (ctl_ff[c][`IETU_CH_INCSRC]) nxt_src[c] = src_ff[c] + step;
        if (ctl_ff[c][`IETU_CH_INCDST]) nxt_dst[c] = dst_ff[c] + step;
        if (!ctl_ff[c][`IETU_CH_CONT]) nxt_ctl[c][7:0] = ctl_ff[c][7:0] - 8'h01;
      end
    end
    nxt_xv = take_etc;
    nxt_xs = take_etc ? src_ff[etc_ch] : xs_ff;
    nxt_xd = take_etc ? dst_ff[etc_ch] : xd_ff;
    nxt_xb = take_etc ? ctl_ff[etc_ch][`IETU_CH_BYTE] : xb_ff;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int c = 0; c < CHANS; c++) begin
        src_ff[c] <= 16'h0000;
        dst_ff[c] <= 16'h0000;
        ctl_ff[c] <= 12'h000;
      end
      xv_ff <= 1'b0;
      xs_ff <= 16'h0000;
      xd_ff <= 16'h0000;
      xb_ff <= 1'b0;
    end else if (CE) begin
      src_ff <= nxt_src;
      dst_ff <= nxt_dst;
      ctl_ff <= nxt_ctl;
      xv_ff <= nxt_xv;
      xs_ff <= nxt_xs;
      xd_ff <= nxt_xd;
      xb_ff <= nxt_xb;
    end
  end

  // ----------------------------------------------------------------
  // Service sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_lat = lat_ff;
    nxt_redirect = 1'b0;
    nxt_vector = vector_ff;
    nxt_cpu_prio = cpu_prio_ff;
    nxt_saved_prio = saved_prio_ff;
    nxt_trap_lvl = trap_lvl_ff;
    nxt_saved_trap = saved_trap_ff;
    if (wr && WB_ADR_I == `IETU_CPUPRIO_ADR && WB_SEL_I[0]) nxt_cpu_prio = WB_DAT_I[3:0];
    if (SVC_RETURN) begin
      nxt_cpu_prio = saved_prio_ff;
      nxt_trap_lvl = saved_trap_ff;
    end
    case (state_ff)
      ietu_pkg::IETU_IDLE: begin
        if (take_sw || take_trap || take_vec) begin
          nxt_state = ietu_pkg::IETU_WAIT;
          // Request cycle, grant cycle and the load cycle are part of the count
          nxt_lat = JUMP_CACHE ? 4'(`IETU_LAT_JC - 3) : 4'(`IETU_LAT_NOJC - 3);
        end
        if (take_sw) begin
          nxt_vector = {1'b0, swt_num_ff};
        end else if (take_trap) begin
          nxt_vector = {4'h0, tr_idx};
          nxt_saved_trap = trap_lvl_ff;
          nxt_trap_lvl = {1'b0, tr_idx} + 5'h01;
        end else if (take_vec) begin
          nxt_vector = `IETU_VEC_NODE_BASE + {2'h0, vec_idx};
          nxt_saved_prio = cpu_prio_ff;
          nxt_cpu_prio = vec_prio;
        end
      end
      ietu_pkg::IETU_WAIT: begin
        nxt_lat = lat_ff - 4'h1;
        if (lat_ff == 4'h0) begin
          nxt_redirect = 1'b1;
          nxt_state = ietu_pkg::IETU_IDLE;
        end
      end
      default: nxt_state = ietu_pkg::IETU_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ietu_pkg::IETU_IDLE;
      lat_ff <= 4'h0;
      redirect_ff <= 1'b0;
      vector_ff <= 8'h00;
      cpu_prio_ff <= `IETU_CPUPRIO_RST;
      saved_prio_ff <= `IETU_CPUPRIO_RST;
      trap_lvl_ff <= 5'h00;
      saved_trap_ff <= 5'h00;
    end else if (CE) begin
      state_ff <= nxt_state;
      lat_ff <= nxt_lat;
      redirect_ff <= nxt_redirect;
      vector_ff <= nxt_vector;
      cpu_prio_ff <= nxt_cpu_prio;
      saved_prio_ff <= nxt_saved_prio;
      trap_lvl_ff <= nxt_trap_lvl;
      saved_trap_ff <= nxt_saved_trap;
    end
  end

  // Outputs
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;
  assign REDIRECT = redirect_ff;
  assign REDIRECT_VECTOR = vector_ff;
  assign CPU_PRIO = cpu_prio_ff;
  assign TRAP_LEVEL = trap_lvl_ff;
  assign XFER_VALID = xv_ff;
  assign XFER_SRC = xs_ff;
  assign XFER_DST = xd_ff;
  assign XFER_BYTE = xb_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  a_lat_cache_on: assert property (take_vec && JUMP_CACHE ##0 CE[*6] |=> redirect_ff)
    else $error("redirect not 7 clocks after request with jump cache");
  a_lat_cache_off: assert property (take_vec && !JUMP_CACHE ##0 CE[*8] ##1 CE[*2] |=> redirect_ff)
    else $error("redirect not 11 clocks after request without jump cache");
  a_trap_blocks_xfer: assert property (trap_lvl_ff != 5'h00 && CE |=> !xv_ff)
    else $error("transfer during trap service");
  a_count_dec: assert property (take_etc && CE && !ctl_ff[etc_ch][`IETU_CH_CONT] |=>
    ctl_ff[$past(etc_ch)][7:0] == $past(ctl_ff[etc_ch][7:0]) - 8'h01 && xv_ff)
    else $error("transfer counter not decremented");
  a_count_hold: assert property (take_etc && CE && ctl_ff[etc_ch][`IETU_CH_CONT] |=>
    ctl_ff[$past(etc_ch)][7:0] == $past(ctl_ff[etc_ch][7:0]))
    else $error("continuous counter changed");
  a_trap_flag_set: assert property (CE && TRAP_IN != 14'h0 |=>
    (tflag_ff[13:0] & $past(TRAP_IN)) == $past(TRAP_IN))
    else $error("trap flag missing");
  a_sw_req_set: assert property (CE && wr && WB_ADR_I[11:8] == `IETU_NODE_PAGE && WB_SEL_I[0] &&
    WB_DAT_I[`IETU_NODE_REQ] |=> req_ff[$past(WB_ADR_I[7:2])] ||
    $past(take_vec && vec_idx == WB_ADR_I[7:2]) || $past(take_etc && etc_idx == WB_ADR_I[7:2]))
    else $error("software request flag not set");
  a_prio_raise: assert property (take_vec && CE |=> cpu_prio_ff > $past(cpu_prio_ff))
    else $error("grant at or below cpu priority");
  a_ack_pulse: assert property (ack_ff && CE |=> !ack_ff)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (CE && wb_req && !ack_ff |=> ack_ff)
    else $error("bus request not acknowledged");

  c_vec_redirect: cover property (take_vec ##[1:12] redirect_ff);
  c_xfer_last: cover property (take_etc && ctl_ff[etc_ch][7:0] == 8'h01 ##[1:20] take_vec);
  c_trap_nest: cover property (take_trap ##[1:30] take_trap);
  c_sw_trap: cover property (take_sw);

endmodule // ietu_top
`default_nettype wire

//--- sim/ietu_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module ietu_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Service handshake
  input wire logic redirect,
  input wire logic slow,
  output logic svc_return
);
  logic [4:0] cnt_ff;
  // Service runs a while, then returns
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 5'h00;
      svc_return <= 1'b0;
    end else begin
      svc_return <= (cnt_ff == 5'h01);
      if (redirect)
        cnt_ff <= slow ? 5'h14 : 5'h03;
      else if (cnt_ff != 5'h00)
        cnt_ff <= cnt_ff - 5'h01;
    end
  end
endmodule // ietu_core_model
`default_nettype wire

//--- sim/tb_interrupt_event_transfer_unit.sv
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_event_transfer_unit;
  logic clk = 0, rst_n = 0, we = 0, cyc = 0, stb = 0, jc = 1, slow = 0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [63:0] nreq = 64'h0;
  logic [13:0] trap = 14'h0;
  logic [3:0] external_request_preprocessor = 4'h0, alt = 4'h0;
  logic [2:0] sp = 3'h0;
  logic ack, svc, red, xv, xb;
  logic [7:0] vec;
  logic [3:0] prio;
  logic [4:0] tlev;
  logic [15:0] xs, xd;
  int n_errors = 0, total_checks = 0, cyc_cnt = 0, n;
  // Clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  ietu_top u_ietu_top (.CLK_SYS(clk), .RESET_N(rst_n), .CE(1'b1), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(4'hF), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_ACK_O(ack), .NODE_REQ_IN(nreq), .SHARED_ALT_IN(alt), .ERU_IN(external_request_preprocessor),
    .TRAP_IN(trap), .SERVICE_PIN_IN(sp), .JUMP_CACHE(jc), .SVC_RETURN(svc), .REDIRECT(red),
    .REDIRECT_VECTOR(vec), .CPU_PRIO(prio), .TRAP_LEVEL(tlev), .XFER_VALID(xv),
    .XFER_SRC(xs), .XFER_DST(xd), .XFER_BYTE(xb));
  ietu_core_model u_ietu_core_model (.clk(clk), .rst_n(rst_n), .redirect(red), .slow(slow),
    .svc_return(svc));
  task automatic end_sim();
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  // Single classic bus cycle
  task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic pulse(input logic [63:0] r, input logic [13:0] t);
    @(posedge clk);
    nreq <= r;
    trap <= t;
    @(posedge clk);
    nreq <= 64'h0;
    trap <= 14'h0;
  endtask
  // Count cycles to redirect, the request cycle being the first
  task automatic wred(input int lat, input logic [7:0] v);
    n = 1;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (red !== 1'b1 && n < 40);
    if (lat != 0) chk(n, lat);
    chk(vec, v);
  endtask
  task automatic wx(input logic [15:0] s, input logic [15:0] d, input logic b);
    do @(posedge clk); while (xv !== 1'b1);
    chk(xs, s);
    chk(xd, d);
    chk(xb, b);
  endtask
  task automatic idle();
    while (prio !== 4'h0 || tlev !== 5'h00) @(posedge clk);
  endtask
  task automatic t_regs();
    wb(12'h000, 0, 0);
    chk(q, 32'h0);
    wb(12'h214, 0, 0);
    chk(q, 32'hF);
    wb(12'hFFC, 0, 0);
    chk(q, 32'h0);
  endtask
  task automatic t_node();
    wb(12'h00C, 1, 32'h15);
    pulse(64'h8, 14'h0);
    wred(7, 8'h13);
    chk(prio, 4'h5);
    idle();
  endtask
  task automatic t_sw();
    wb(12'h010, 1, 32'h16);
    jc <= 1'b0;
    slow <= 1'b1;
    wb(12'h010, 1, 32'h36);
    wred(11, 8'h14);
    chk(prio, 4'h6);
    idle();
    jc <= 1'b1;
    slow <= 1'b0;
  endtask
  task automatic t_trap();
    pulse(64'h0, 14'h4);
    wred(7, 8'h02);
    chk(tlev, 5'h03);
    wb(12'h208, 0, 0);
    chk(q, 32'h4);
    wb(12'h208, 1, 32'h4);
    idle();
  endtask
  // Pin trap, then a lower trap and a node held off by it
  task automatic t_pins();
    wb(12'h214, 1, 32'hD);
    sp <= 3'h2;
    slow <= 1'b1;
    wred(0, 8'h0E);
    chk(tlev, 5'h0F);
    wb(12'h208, 0, 0);
    chk(q, 32'h4000);
    pulse(64'h8, 14'h4);
    repeat (3) @(posedge clk);
    chk(tlev, 5'h0F);
    wred(0, 8'h02);
    chk(tlev, 5'h03);
    wred(0, 8'h13);
    idle();
    slow <= 1'b0;
    sp <= 3'h0;
  endtask
  // Input 1 rising edge to gate 2, match mode blocks, miss mode passes
  task automatic t_eru();
    wb(12'h0E8, 1, 32'h19);
    wb(12'h204, 1, 32'h0010_0804);
    external_request_preprocessor <= 4'h2;
    repeat (4) @(posedge clk);
    wb(12'h0E8, 0, 0);
    chk(q, 32'h19);
    external_request_preprocessor <= 4'h0;
    wb(12'h204, 1, 32'h0020_0804);
    external_request_preprocessor <= 4'h2;
    wred(0, 8'h4A);
    idle();
    external_request_preprocessor <= 4'h0;
  endtask
  // Shared node 60 follows its alternate source only
  task automatic t_share();
    wb(12'h200, 1, 32'h1);
    wb(12'h0F0, 1, 32'h1A);
    pulse(64'h1000_0000_0000_0000, 14'h0);
    wb(12'h0F0, 0, 0);
    chk(q, 32'h1A);
    alt <= 4'h1;
    @(posedge clk);
    alt <= 4'h0;
    wred(0, 8'h4C);
    idle();
  endtask
  // Software trap, then a continuous word transfer
  task automatic t_cont();
    wb(12'h218, 1, 32'h25);
    wred(7, 8'h25);
    wb(12'h218, 0, 0);
    chk(q, 32'h25);
    idle();
    wb(12'h100, 1, 32'h3000_0400);
    wb(12'h104, 1, 32'h600);
    wb(12'h018, 1, 32'h58);
    pulse(64'h40, 14'h0);
    wx(16'h0400, 16'h3000, 1'b0);
    wb(12'h104, 0, 0);
    chk(q, 32'h600);
    wb(12'h100, 0, 0);
    chk(q, 32'h3002_0400);
  endtask
  task automatic t_xfer();
    wb(12'h138, 1, 32'h2000_1000);
    wb(12'h13C, 1, 32'hB02);
    wb(12'h014, 1, 32'h3D7);
    pulse(64'h20, 14'h0);
    wx(16'h1000, 16'h2000, 1'b1);
    pulse(64'h20, 14'h0);
    wx(16'h1001, 16'h2001, 1'b1);
    wred(0, 8'h15);
    wb(12'h13C, 0, 0);
    chk(q, 32'hB00);
    wb(12'h138, 0, 0);
    chk(q, 32'h2002_1002);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_node();
    t_sw();
    t_trap();
    t_pins();
    t_eru();
    t_share();
    t_cont();
    t_xfer();
    end_sim();
  end
endmodule // tb_interrupt_event_transfer_unit
`default_nettype wire
